//--- hdl/tsr_params.svh
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
// Functional notes
// - Only pointer bits 2:0 choose the register for later reads and writes.
// - Code 0 selects the read-only temperature result, the default selection.
// - Code 1 selects configuration, code 2 the lower limit; both read/write.
// - Code 3 selects the upper limit, readable and writable.
// - Code 4 is write-only; any write in idle starts a conversion, mode permitting.
// - Pointer register is write-only, select in bits 2:0, resets to zero.
// - Temperature sits in bits 15:4, 1/16 degree LSB; bits 3:0 read zero.
// - Temperature result reads zero after reset until the first result lands.
// - Configuration resets to zero, low byte reads zero, fields at 13..8.
// - Shutdown and one-shot both clear means continuous conversion, the default.
// - One-shot set: idle; each trigger write in idle runs one conversion, then idle.
// - Shutdown set: stay shut down, trigger writes start nothing.
// - Fault queue codes 0..3 need 1, 2, 4 or 6 consecutive faults.
// - Polarity bit clear gives an active-low alert pin, set gives active-high.
// - Mode bit clear gives comparator alert, set gives interrupt alert.
// - Shutdown bit clear runs conversions as the one-shot bit selects, set shuts down.
// - Lower limit holds 12 bits in 15:4, high byte resets to 4b; 3:0 zero.
// - Lower limit resets to 4b00, 75 degrees, at pointer code two.
// - Upper limit resets to 5000, 80 degrees, same layout, pointer code three.
// - Entering shutdown clears the alert pin and fault counter in both modes.
// - Continuous mode starts a conversion every 80 ms; each takes 27 ms.

// Pointer codes
`define TSR_PTR_TEMP    3'h0
`define TSR_PTR_CFG     3'h1
`define TSR_PTR_LOW     3'h2
`define TSR_PTR_HIGH    3'h3
`define TSR_PTR_TRIG    3'h4
`define TSR_PTR_RST     3'h0

// Configuration field positions
`define TSR_CFG_OS_BIT  13
`define TSR_CFG_FQ_HI   12
`define TSR_CFG_FQ_LO   11
`define TSR_CFG_POL_BIT 10
`define TSR_CFG_TM_BIT  9
`define TSR_CFG_SD_BIT  8

// Reset values
`define TSR_TEMP_RST    16'h0000
`define TSR_CFG_RST     16'h0000
`define TSR_LOW_RST     16'h4b00
`define TSR_HIGH_RST    16'h5000

// Fault queue depths for codes 0..3
`define TSR_FQ_N0       3'h1
`define TSR_FQ_N1       3'h2
`define TSR_FQ_N2       3'h4
`define TSR_FQ_N3       3'h6

// Timing
`define TSR_CLK_KHZ       200000
`define TSR_CONV_TIME_MS  27
`define TSR_PERIOD_MS     80
`define TSR_CONV_CYC      (`TSR_CONV_TIME_MS * `TSR_CLK_KHZ)
`define TSR_PERIOD_CYC    (`TSR_PERIOD_MS * `TSR_CLK_KHZ)

`endif

//--- hdl/tsr_pkg.sv
`include "tsr_params.svh"

package tsr_pkg;

  // Conversion sequencer states
  typedef enum logic [2:0] {
    TSR_S_IDLE = 3'b001,
    TSR_S_CONV = 3'b010,
    TSR_S_WAIT = 3'b100
  } tsr_state_t;

  typedef logic [11:0] tsr_temp_t;
  typedef logic [2:0]  tsr_ptr_t;

  // Consecutive faults needed for a fault queue code
  function automatic logic [2:0] tsr_fq_limit(input logic [1:0] code);
    unique case (code)
      2'h0: tsr_fq_limit = `TSR_FQ_N0;
      2'h1: tsr_fq_limit = `TSR_FQ_N1;
      2'h2: tsr_fq_limit = `TSR_FQ_N2;
      2'h3: tsr_fq_limit = `TSR_FQ_N3;
    endcase
  endfunction : tsr_fq_limit

endpackage : tsr_pkg

//--- hdl/tsr_alert_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tsr_alert_if;
  import tsr_pkg::*;
  logic      result_stb;
  tsr_temp_t temp;
  tsr_temp_t lower;
  tsr_temp_t upper;
  logic [1:0] fault_queue_len;
  logic      alert_active_level;
  logic      compare_or_irq_sel;
  logic      shutdown_ctl;
  logic      rd_ack;
  logic      flag_pin;

  modport reg_side (
    output result_stb, temp, lower, upper, fault_queue_len,
    output alert_active_level, compare_or_irq_sel, shutdown_ctl, rd_ack,
    input  flag_pin
  );
  modport alert_side (
    input  result_stb, temp, lower, upper, fault_queue_len,
    input  alert_active_level, compare_or_irq_sel, shutdown_ctl, rd_ack,
    output flag_pin
  );
endinterface : tsr_alert_if

`default_nettype wire

//--- hdl/tsr_alert.sv
`timescale 1ns/1ps
`default_nettype none

module tsr_alert (
  input wire logic     clock_i,
  input wire logic     reset_n_i,
  tsr_alert_if.alert_side al
);
  import tsr_pkg::*;

  logic [2:0] hot_r, hot_nxt;
  logic [2:0] cold_r, cold_nxt;
  logic       active_r, active_nxt;
  logic       pin_r, pin_nxt;
  logic [2:0] limit;

  assign limit = tsr_fq_limit(al.fault_queue_len);
  assign al.flag_pin = pin_r;

  // Fault queue and alert state; counters saturate so a long fault run cannot wrap
  always_comb
  begin
    hot_nxt    = hot_r;
    cold_nxt   = cold_r;
    active_nxt = active_r;
    if (al.result_stb)
    begin
      if ($signed(al.temp) >= $signed(al.upper))
      begin
        hot_nxt  = (hot_r == 3'h7) ? hot_r : hot_r + 3'h1;
        cold_nxt = 3'h0;
      end
      else if ($signed(al.temp) < $signed(al.lower))
      begin
        cold_nxt = (cold_r == 3'h7) ? cold_r : cold_r + 3'h1;
        hot_nxt  = 3'h0;
      end
      else
      begin
        hot_nxt  = 3'h0;
        cold_nxt = 3'h0;
      end
      if (hot_nxt == limit)
        active_nxt = 1'b1;
      else if (!al.compare_or_irq_sel && cold_nxt == limit)
        active_nxt = 1'b0;
    end
    // Interrupt mode holds until software reads any register
    if (al.compare_or_irq_sel && al.rd_ack && !(al.result_stb && hot_nxt == limit))
      active_nxt = 1'b0;
    if (al.shutdown_ctl)
    begin
      hot_nxt    = 3'h0;
      cold_nxt   = 3'h0;
      active_nxt = 1'b0;
    end
    pin_nxt = al.alert_active_level ? active_nxt : !active_nxt;
  end

  // State registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      hot_r    <= 3'h0;
      cold_r   <= 3'h0;
      active_r <= 1'b0;
      pin_r    <= 1'b1;
    end
    else
    begin
      hot_r    <= hot_nxt;
      cold_r   <= cold_nxt;
      active_r <= active_nxt;
      pin_r    <= pin_nxt;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sd_clears_alert_a: assert property (
    al.shutdown_ctl |=> !active_r && hot_r == 3'h0 && cold_r == 3'h0)
    else $error("shutdown did not clear alert state");

  pin_polarity_a: assert property (
    pin_r == ($past(al.alert_active_level) ? active_r : !active_r))
    else $error("alert pin polarity wrong");

  queue_depth_a: assert property (
    $rose(active_r) |-> hot_r == tsr_fq_limit($past(al.fault_queue_len)))
    else $error("alert raised at wrong fault count");

  comp_hold_a: assert property (
    active_r && !al.compare_or_irq_sel && !al.result_stb && !al.shutdown_ctl |=> active_r)
    else $error("comparator alert dropped without a result");

endmodule : tsr_alert

`default_nettype wire

//--- hdl/tsr_regbank.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"

module tsr_regbank #(
  parameter int CONV_CYC   = `TSR_CONV_CYC,
  parameter int PERIOD_CYC = `TSR_PERIOD_CYC,
  parameter int CNT_W      = 24
) (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        ptr_wr_i,
  input  wire logic [7:0]  ptr_byte_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_req_i,
  input  wire tsr_pkg::tsr_temp_t adc_code_i,
  output logic [15:0]      rd_data_o,
  output logic             rd_valid_o,
  output logic             conv_busy_o,
  output logic             over_temp_flag_o
);
  import tsr_pkg::*;

  localparam logic [CNT_W-1:0] CONV_LAST   = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);

  // A conversion must fit inside its period and the counter must reach the period
  generate
    if (CONV_CYC < 1 || PERIOD_CYC <= CONV_CYC || PERIOD_CYC >= (2 ** CNT_W))
    begin : g_bad_timing
      $error("tsr_regbank: timing parameters out of range");
    end
  endgenerate

  tsr_ptr_t   ptr_r, ptr_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  tsr_temp_t  low_r, low_nxt;
  tsr_temp_t  high_r, high_nxt;
  tsr_temp_t  temp_r, temp_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;
  logic       rd_valid_r;
  logic       trig;
  tsr_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic       stb_r, stb_nxt;
  logic       sd, os;

  tsr_alert_if al_if ();

  assign sd   = cfg_r[`TSR_CFG_SD_BIT - 8];
  assign os   = cfg_r[`TSR_CFG_OS_BIT - 8];
  assign trig = reg_wr_i && (ptr_r == `TSR_PTR_TRIG);

  // Pointer and writable registers; a write goes to the register selected before it
  always_comb
  begin
    ptr_nxt  = ptr_r;
    cfg_nxt  = cfg_r;
    low_nxt  = low_r;
    high_nxt = high_r;
    if (ptr_wr_i)
      ptr_nxt = ptr_byte_i[2:0];
    if (reg_wr_i)
    begin
      case (ptr_r)
        `TSR_PTR_CFG:  cfg_nxt  = wr_data_i[15:8];
        `TSR_PTR_LOW:  low_nxt  = wr_data_i[15:4];
        `TSR_PTR_HIGH: high_nxt = wr_data_i[15:4];
        default:       cfg_nxt  = cfg_r; // Result, trigger and unused codes store nothing
      endcase
    end
  end

  // Read mux; write-only and unused codes answer zero
  always_comb
  begin
    case (ptr_r)
      `TSR_PTR_TEMP: rd_data_nxt = {temp_r, 4'h0};
      `TSR_PTR_CFG:  rd_data_nxt = {cfg_r, 8'h00};
      `TSR_PTR_LOW:  rd_data_nxt = {low_r, 4'h0};
      `TSR_PTR_HIGH: rd_data_nxt = {high_r, 4'h0};
      default:       rd_data_nxt = 16'h0000;
    endcase
    if (!rd_req_i)
      rd_data_nxt = rd_data_r;
  end

  // Register file storage
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      ptr_r      <= `TSR_PTR_RST;
      cfg_r      <= 8'(`TSR_CFG_RST >> 8);
      low_r      <= 12'(`TSR_LOW_RST >> 4);
      high_r     <= 12'(`TSR_HIGH_RST >> 4);
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      ptr_r      <= ptr_nxt;
      cfg_r      <= cfg_nxt;
      low_r      <= low_nxt;
      high_r     <= high_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_req_i;
    end
  end

  // Conversion sequencer; the counter runs from each conversion start so the
  // start-to-start spacing is the full period, not conversion plus delay
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + CNT_W'(1);
    temp_nxt  = temp_r;
    stb_nxt   = 1'b0;
    unique case (state_r)
      TSR_S_IDLE:
      begin
        cnt_nxt = '0;
        if (!os || trig)
          state_nxt = TSR_S_CONV;
      end
      TSR_S_CONV:
      begin
        if (cnt_r == CONV_LAST)
        begin
          temp_nxt  = adc_code_i;
          stb_nxt   = 1'b1;
          state_nxt = os ? TSR_S_IDLE : TSR_S_WAIT;
        end
      end
      TSR_S_WAIT:
      begin
        if (os)
          state_nxt = TSR_S_IDLE;
        else if (cnt_r == PERIOD_LAST)
        begin
          state_nxt = TSR_S_CONV;
          cnt_nxt   = '0;
        end
      end
    endcase
    // Shutdown aborts any conversion in flight and blocks triggers
    if (sd)
    begin
      state_nxt = TSR_S_IDLE;
      cnt_nxt   = '0;
      stb_nxt   = 1'b0;
      temp_nxt  = temp_r;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= TSR_S_IDLE;
      cnt_r   <= '0;
      temp_r  <= 12'(`TSR_TEMP_RST >> 4);
      stb_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      temp_r  <= temp_nxt;
      stb_r   <= stb_nxt;
    end
  end

  // Feed the alert logic
  assign al_if.result_stb         = stb_r;
  assign al_if.temp               = temp_r;
  assign al_if.lower              = low_r;
  assign al_if.upper              = high_r;
  assign al_if.fault_queue_len    = cfg_r[`TSR_CFG_FQ_HI - 8:`TSR_CFG_FQ_LO - 8];
  assign al_if.alert_active_level = cfg_r[`TSR_CFG_POL_BIT - 8];
  assign al_if.compare_or_irq_sel = cfg_r[`TSR_CFG_TM_BIT - 8];
  assign al_if.shutdown_ctl       = sd;
  assign al_if.rd_ack             = rd_valid_r;

  tsr_alert u_alert (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .al        (al_if.alert_side)
  );

  assign rd_data_o        = rd_data_r;
  assign rd_valid_o       = rd_valid_r;
  assign conv_busy_o      = state_r[1];
  assign over_temp_flag_o = al_if.flag_pin;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_os_conv_end;
    state_r == TSR_S_CONV && cnt_r == CONV_LAST && os && !sd;
  endsequence

  ptr_latch_a: assert property (
    ptr_wr_i |=> ptr_r == $past(ptr_byte_i[2:0]))
    else $error("pointer not latched from low bits");

  // A result may land on the read edge, so the word is judged against the old value
  temp_read_a: assert property (
    rd_req_i && ptr_r == `TSR_PTR_TEMP |=> rd_data_o == {$past(temp_r), 4'h0} && rd_valid_o)
    else $error("temperature read wrong");

  cfg_read_a: assert property (
    rd_req_i && ptr_r == `TSR_PTR_CFG |=> rd_data_o[7:0] == 8'h00)
    else $error("config low byte not zero");

  high_write_a: assert property (
    reg_wr_i && ptr_r == `TSR_PTR_HIGH |=> high_r == $past(wr_data_i[15:4]))
    else $error("upper limit write lost");

  sd_no_conv_a: assert property (
    sd |=> state_r == TSR_S_IDLE)
    else $error("conversion ran in shutdown");

  os_trigger_a: assert property (
    state_r == TSR_S_IDLE && os && !sd && trig |=> state_r == TSR_S_CONV)
    else $error("trigger did not start conversion");

  // A trigger or a cleared one-shot bit right after the result may restart at once
  os_return_a: assert property (
    s_os_conv_end |=> (state_r == TSR_S_IDLE && stb_r)
      ##1 (state_r == TSR_S_IDLE || $past(trig) || !$past(os)))
    else $error("one-shot did not return to idle");

  period_restart_a: assert property (
    state_r == TSR_S_WAIT && cnt_r == PERIOD_LAST && !sd && !os
      |=> state_r == TSR_S_CONV && cnt_r == '0)
    else $error("continuous restart missed");

  // Writes land in the register selected before the strobe
  cfg_write_a: assert property (
    reg_wr_i && ptr_r == `TSR_PTR_CFG |=> cfg_r == $past(wr_data_i[15:8]))
    else $error("configuration write lost");

  low_write_a: assert property (
    reg_wr_i && ptr_r == `TSR_PTR_LOW |=> low_r == $past(wr_data_i[15:4]))
    else $error("lower limit write lost");

  // Read words carry the stored fields with their reserved bits at zero
  cfg_value_a: assert property (
    rd_req_i && ptr_r == `TSR_PTR_CFG |=> rd_data_o[15:8] == $past(cfg_r))
    else $error("configuration read wrong");

  low_read_a: assert property (
    rd_req_i && ptr_r == `TSR_PTR_LOW |=> rd_data_o == {$past(low_r), 4'h0})
    else $error("lower limit read wrong");

  high_read_a: assert property (
    rd_req_i && ptr_r == `TSR_PTR_HIGH |=> rd_data_o == {$past(high_r), 4'h0})
    else $error("upper limit read wrong");

  wo_read_zero_a: assert property (
    rd_req_i && ptr_r >= `TSR_PTR_TRIG |=> rd_data_o == 16'h0000)
    else $error("write-only code read not zero");

  // Without a strobe the pointer and the read port keep what they hold
  ptr_hold_a: assert property (
    !ptr_wr_i |=> $stable(ptr_r))
    else $error("pointer changed without a write");

  rd_idle_a: assert property (
    !rd_req_i |=> !rd_valid_o && $stable(rd_data_o))
    else $error("read port moved without a request");

  // The result only changes at the end of a conversion
  temp_hold_a: assert property (
    !(state_r == TSR_S_CONV && cnt_r == CONV_LAST) |=> $stable(temp_r))
    else $error("result changed outside a conversion end");

  temp_load_a: assert property (
    state_r == TSR_S_CONV && cnt_r == CONV_LAST && !sd
      |=> temp_r == $past(adc_code_i) && stb_r)
    else $error("conversion result not stored");

  cont_start_a: assert property (
    state_r == TSR_S_IDLE && !os && !sd |=> state_r == TSR_S_CONV)
    else $error("continuous mode did not start");

  conv_run_a: assert property (
    state_r == TSR_S_CONV && cnt_r != CONV_LAST && !sd |=> state_r == TSR_S_CONV)
    else $error("conversion cut short");

  wait_hold_a: assert property (
    state_r == TSR_S_WAIT && cnt_r != PERIOD_LAST && !os && !sd |=> state_r == TSR_S_WAIT)
    else $error("continuous delay cut short");

  // One-shot idles until a trigger write arrives
  idle_wait_a: assert property (
    state_r == TSR_S_IDLE && os && !trig |=> state_r == TSR_S_IDLE)
    else $error("one-shot left idle without trigger");

  sd_busy_a: assert property (
    sd |=> !conv_busy_o)
    else $error("busy in shutdown");

endmodule : tsr_regbank

`default_nettype wire

//--- dv/tsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Register-port host; every strobe is a one-cycle pulse launched on the falling edge
module tsr_host_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_valid_i,
  output logic             ptr_wr_o,
  output logic [7:0]       ptr_byte_o,
  output logic             reg_wr_o,
  output logic [15:0]      wr_data_o,
  output logic             rd_req_o
);
  // Idle levels from time zero
  initial
  begin
    ptr_wr_o   = 1'b0;
    ptr_byte_o = 8'h00;
    reg_wr_o   = 1'b0;
    wr_data_o  = 16'h0000;
    rd_req_o   = 1'b0;
  end

  // Pointer write; the byte is scrambled afterwards so stale data cannot help
  task automatic set_ptr(input logic [7:0] p);
    @(negedge clock_i);
    ptr_wr_o   = 1'b1;
    ptr_byte_o = p;
    @(negedge clock_i);
    ptr_wr_o   = 1'b0;
    ptr_byte_o = ~p;
  endtask : set_ptr

  // Data word write to whatever the pointer selects
  task automatic write_word(input logic [15:0] d);
    @(negedge clock_i);
    reg_wr_o  = 1'b1;
    wr_data_o = d;
    @(negedge clock_i);
    reg_wr_o  = 1'b0;
    wr_data_o = ~d;
  endtask : write_word

  // Configuration update; reserved bits always go out as zero
  task automatic write_cfg(input logic [15:0] d);
    set_ptr(8'h01);
    write_word(d & 16'h3f00);
  endtask : write_cfg

  // Read; valid stands for the one cycle after the request edge, so it is
  // looked at on the falling edges that follow, at most 4 of them
  task automatic read_word(output logic [15:0] d, output logic ok);
    int k;
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge clock_i);
    rd_req_o = 1'b1;
    for (k = 0; k < 4 && !ok; k++)
    begin
      @(negedge clock_i);
      rd_req_o = 1'b0;
      ok       = (rd_valid_i === 1'b1);
      if (ok)
        d = rd_data_i;
    end
  endtask : read_word
endmodule : tsr_host_model

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tsr_pkg::*;
  localparam int CONV = 20;
  localparam int PER  = 60;
  logic        clock_i;
  logic        reset_n_i;
  logic        ptr_wr;
  logic [7:0]  ptr_byte;
  logic        reg_wr;
  logic [15:0] wr_data;
  logic        rd_req;
  tsr_temp_t   adc_code;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        busy;
  logic        flag;
  int          num_errors = 0;
  int          n_compared = 0;
  int          dep[4]     = '{1, 2, 4, 6};

  // Short counts keep each conversion period to 60 cycles
  tsr_regbank #(
    .CONV_CYC   (CONV),
    .PERIOD_CYC (PER)
  ) tsr_regbank_i (
    .clock_i          (clock_i),
    .reset_n_i        (reset_n_i),
    .ptr_wr_i         (ptr_wr),
    .ptr_byte_i       (ptr_byte),
    .reg_wr_i         (reg_wr),
    .wr_data_i        (wr_data),
    .rd_req_i         (rd_req),
    .adc_code_i       (adc_code),
    .rd_data_o        (rd_data),
    .rd_valid_o       (rd_valid),
    .conv_busy_o      (busy),
    .over_temp_flag_o (flag)
  );

  tsr_host_model tsr_host_model_i (
    .clock_i    (clock_i),
    .rd_data_i  (rd_data),
    .rd_valid_i (rd_valid),
    .ptr_wr_o   (ptr_wr),
    .ptr_byte_o (ptr_byte),
    .reg_wr_o   (reg_wr),
    .wr_data_o  (wr_data),
    .rd_req_o   (rd_req)
  );

  // 200 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Word compare; bits go through it zero-extended
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16

  task automatic chk1(input string nm, input logic e, input logic s);
    chk16(nm, {15'h0000, e}, {15'h0000, s});
  endtask : chk1

  // Optional pointer write, then one read judged against e
  task automatic rd(input logic up, input logic [7:0] p, input logic [15:0] e, input string nm);
    logic [15:0] d;
    logic        ok;
    if (up)
      tsr_host_model_i.set_ptr(p);
    tsr_host_model_i.read_word(d, ok);
    chk1("rd_valid_o", 1'b1, ok);
    chk16(nm, e, d);
  endtask : rd

  // Bounded wait for a busy level; running out ends the run as a mismatch
  task automatic wbusy(input logic lvl, input int max);
    int k;
    for (k = 0; k < max; k++)
    begin
      @(posedge clock_i);
      #1;
      if (busy === lvl)
        return;
    end
    num_errors++;
    $display("[FAIL] conv_busy_o expected %b seen %b", lvl, busy);
    complete_run();
  endtask : wbusy

  // Cycles for which busy keeps the level it has now
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (busy === lvl && n < 1000)
    begin
      n++;
      @(posedge clock_i);
      #1;
    end
  endtask : run_len

  // Busy must never rise for n cycles
  task automatic idle_for(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge clock_i);
      #1;
      hit |= (busy !== 1'b0);
    end
    chk1("conv_busy_o held low", 1'b0, hit);
  endtask : idle_for

  // One whole conversion, then time for the alert pin to follow the result
  task automatic conv_wait();
    wbusy(1'b1, PER + 10);
    wbusy(1'b0, CONV + 5);
    repeat (4) @(posedge clock_i);
    #1;
  endtask : conv_wait

  task automatic t_reset();
    rd(1'b0, 8'h00, 16'h0000, "temp_result");
    rd(1'b1, 8'h02, 16'h4b00, "lower_limit");
    rd(1'b1, 8'h03, 16'h5000, "upper_limit");
    rd(1'b1, 8'h01, 16'h0000, "config_ctl");
    chk1("over_temp_flag_o", 1'b1, flag);
    tsr_host_model_i.set_ptr(8'h02);
    tsr_host_model_i.write_word(16'h080f);
    rd(1'b0, 8'h00, 16'h0800, "lower_limit");
    rd(1'b0, 8'h00, 16'h0800, "lower_limit again");
    tsr_host_model_i.set_ptr(8'h03);
    tsr_host_model_i.write_word(16'h100a);
    rd(1'b0, 8'h00, 16'h1000, "upper_limit");
    rd(1'b1, 8'h04, 16'h0000, "trigger read");
    $display("reset and register access done");
  endtask : t_reset

  task automatic t_cont();
    int n;
    wbusy(1'b0, CONV + 5);
    wbusy(1'b1, PER);
    run_len(1'b1, n);
    chk16("conversion length", 16'(CONV), 16'(n));
    run_len(1'b0, n);
    chk16("conversion gap", 16'(PER - CONV), 16'(n));
    rd(1'b1, 8'hf8, 16'h19a0, "temp_result");
    tsr_host_model_i.write_word(16'h5555);
    rd(1'b0, 8'h00, 16'h19a0, "temp_result after write");
    chk1("over_temp_flag_o", 1'b0, flag);
    $display("continuous conversion done");
  endtask : t_cont

  task automatic t_depth();
    int c;
    int k;
    for (c = 0; c < 4; c++)
    begin
      tsr_host_model_i.write_cfg(16'h0100);
      repeat (3) @(posedge clock_i);
      #1;
      chk1("over_temp_flag_o in shutdown", 1'b1, flag);
      tsr_host_model_i.write_cfg({3'h0, 2'(c), 11'h000});
      for (k = 1; k < 9; k++)
      begin
        conv_wait();
        if (flag === 1'b0)
          break;
      end
      chk16("faults to alert", 16'(dep[c]), 16'(k));
    end
    $display("fault queue done");
  endtask : t_depth

  task automatic t_modes();
    tsr_host_model_i.write_cfg(16'h0400);
    conv_wait();
    chk1("over_temp_flag_o high active", 1'b1, flag);
    rd(1'b1, 8'h00, 16'h19a0, "temp_result");
    chk1("comparator flag after read", 1'b1, flag);
    @(negedge clock_i);
    adc_code = 12'h050;
    conv_wait();
    chk1("comparator flag below lower", 1'b0, flag);
    @(negedge clock_i);
    adc_code = 12'h19a;
    tsr_host_model_i.write_cfg(16'h0100);
    tsr_host_model_i.write_cfg(16'h0200);
    conv_wait();
    chk1("interrupt flag", 1'b0, flag);
    rd(1'b1, 8'h01, 16'h0200, "config_ctl");
    repeat (3) @(posedge clock_i);
    #1;
    chk1("interrupt flag after read", 1'b1, flag);
    $display("alert modes done");
  endtask : t_modes

  task automatic t_shut();
    tsr_host_model_i.set_ptr(8'hf9);
    tsr_host_model_i.write_word(16'h3f00);
    rd(1'b0, 8'h00, 16'h3f00, "config_ctl");
    chk1("conv_busy_o in shutdown", 1'b0, busy);
    chk1("over_temp_flag_o in shutdown", 1'b0, flag);
    @(negedge clock_i);
    adc_code = 12'h2a5;
    tsr_host_model_i.set_ptr(8'h04);
    tsr_host_model_i.write_word(16'h00a5);
    idle_for(2 * PER);
    rd(1'b1, 8'h00, 16'h19a0, "temp_result kept");
    $display("shutdown done");
  endtask : t_shut

  task automatic t_one();
    int n;
    tsr_host_model_i.write_cfg(16'h2000);
    idle_for(PER + 10);
    tsr_host_model_i.set_ptr(8'h04);
    tsr_host_model_i.write_word(16'h0000);
    // Busy rose on the trigger edge; counting starts now so that cycle is not lost
    chk1("conv_busy_o after trigger", 1'b1, busy);
    run_len(1'b1, n);
    chk16("single conversion length", 16'(CONV), 16'(n));
    rd(1'b1, 8'h00, 16'h2a50, "temp_result new");
    idle_for(PER);
    $display("one-shot done");
  endtask : t_one

  // Main sequence: reset held 10 cycles, released on a falling edge
  initial
  begin
    reset_n_i = 1'b0;
    adc_code  = 12'h19a;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    reset_n_i = 1'b1;
    t_reset();
    t_cont();
    t_depth();
    t_modes();
    t_shut();
    t_one();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
